// File: core/bof_bit_ops_flag_unit.sv
`timescale 1ns/10ps
`default_nettype none
module bof_bit_ops_flag_unit
  import bof_pkg::*;
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  // Operation request
  input  wire logic       I_OP_VALID,
  input  wire bof_req_t   I_OP,
  output logic            O_OP_READY,
  // Operation result
  output bof_res_t        O_RES,
  output logic [7:0]      O_FLAGS,
  output logic            O_BREAK,
  output logic            O_SLEEP,
  output logic            O_WDR,
  // Data access through nonvolatile memory
  input  wire logic       I_MEM_REQ,
  input  wire logic       I_MEM_SLOW,
  input  wire logic       I_CTRL_BUSY,
  input  wire logic       I_CTRL_CONTEND,
  output logic            O_STALL,
  // Register port
  input  wire logic [3:0] I_REG_ADDR,
  input  wire logic [7:0] I_REG_WDATA,
  input  wire logic       I_REG_WR,
  input  wire logic       I_REG_RD,
  output logic [7:0]      O_REG_RDATA
);

  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] sh_val;
  logic       sh_carry;
  logic       sh_half;
  logic       op_take;
  logic       stall;
  logic [7:0] last_stall;
  bof_res_t   res_d;

  assign op_take    = I_OP_VALID & ~stall;
  assign O_OP_READY = ~stall;
  assign O_STALL    = stall;
  assign O_FLAGS    = flags_q;

  bof_shift_unit u_shift (
    .i_op    (I_OP.op),
    .i_val   (I_OP.rd_val),
    .i_carry (flags_q[FLG_C]),
    .o_val   (sh_val),
    .o_carry (sh_carry),
    .o_half  (sh_half)
  );

  bof_slow_stall u_stall (
    .i_clk          (I_CLK),
    .i_rst          (I_RST),
    .i_mem_req      (I_MEM_REQ),
    .i_mem_slow     (I_MEM_SLOW),
    .i_ctrl_busy    (I_CTRL_BUSY),
    .i_ctrl_contend (I_CTRL_CONTEND),
    .o_stall       (stall),
    .o_last_stall  (last_stall)
  );

  // Next status flags; the flag bits an operation updates override a software write
  always_comb begin
    flags_d = flags_q;
    if (I_REG_WR && I_REG_ADDR == REG_STATUS_FLAGS) begin
      flags_d = I_REG_WDATA;
    end
    if (op_take) begin
      case (I_OP.op)
        OP_LOGICAL_LEFT_SHIFT, OP_ROTATE_LEFT_VIA_CARRY: begin
          flags_d[FLG_C] = sh_carry;
          flags_d[FLG_Z] = (sh_val == 8'h00);
          flags_d[FLG_N] = sh_val[7];
          flags_d[FLG_V] = sh_val[7] ^ sh_carry;
          flags_d[FLG_H] = sh_half;
        end
        OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_RIGHT_VIA_CARRY,
        OP_ARITH_RIGHT_SHIFT: begin
          flags_d[FLG_C] = sh_carry;
          flags_d[FLG_Z] = (sh_val == 8'h00);
          flags_d[FLG_N] = sh_val[7];
          flags_d[FLG_V] = sh_val[7] ^ sh_carry;
        end
        OP_REG_BIT_TO_TRANSFER_FLAG: begin
          flags_d[FLG_T] = I_OP.rd_val[I_OP.bit_sel];
        end
        OP_STATUS_BIT_SET: begin
          flags_d[I_OP.bit_sel] = 1'b1;
        end
        OP_STATUS_BIT_CLEAR: begin
          flags_d[I_OP.bit_sel] = 1'b0;
        end
        default: begin
          flags_d = flags_d;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Register and I/O write-back
  always_comb begin
    res_d         = '0;
    res_d.io_addr = I_OP.io_addr;
    res_d.io_val  = I_OP.io_val;
    res_d.rd_val  = sh_val;
    if (op_take) begin
      case (I_OP.op)
        OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
        OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY,
        OP_ARITH_RIGHT_SHIFT, OP_NIBBLE_SWAP: begin
          res_d.rd_we = 1'b1;
        end
        OP_IO_BIT_SET: begin
          res_d.io_we                = 1'b1;
          res_d.io_val[I_OP.bit_sel] = 1'b1;
        end
        OP_IO_BIT_CLEAR: begin
          res_d.io_we                = 1'b1;
          res_d.io_val[I_OP.bit_sel] = 1'b0;
        end
        OP_TRANSFER_FLAG_TO_REG_BIT: begin
          res_d.rd_we                = 1'b1;
          res_d.rd_val               = I_OP.rd_val;
          res_d.rd_val[I_OP.bit_sel] = flags_q[FLG_T];
        end
        default: begin
          res_d.rd_we = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RES <= '0;
    end else begin
      O_RES <= res_d;
    end
  end

  // Control pulses toward debug, sleep and watchdog logic
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_BREAK <= 1'b0;
      O_SLEEP <= 1'b0;
      O_WDR   <= 1'b0;
    end else begin
      O_BREAK <= op_take && (I_OP.op == OP_BREAK);
      O_SLEEP <= op_take && (I_OP.op == OP_SLEEP);
      O_WDR   <= op_take && (I_OP.op == OP_WATCHDOG_RESET);
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_REG_RDATA <= 8'h00;
    end else if (I_REG_RD) begin
      case (I_REG_ADDR)
        REG_STATUS_FLAGS: O_REG_RDATA <= flags_q;
        REG_LAST_STALL:   O_REG_RDATA <= last_stall;
        REG_STALL_STATE:  O_REG_RDATA <= {7'h00, stall};
        default:          O_REG_RDATA <= 8'h00;
      endcase
    end else begin
      O_REG_RDATA <= 8'h00;
    end
  end

  // Helper copies of the accepted operation
  logic       take_q;
  bof_req_t   req_q;
  logic [7:0] pre_q;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      take_q <= 1'b0;
      req_q  <= '0;
      pre_q  <= FLAGS_RST;
    end else begin
      take_q <= op_take && !(I_REG_WR && I_REG_ADDR == REG_STATUS_FLAGS);
      req_q  <= I_OP;
      pre_q  <= flags_q;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  rot_left_a: assert property (take_q && req_q.op == OP_ROTATE_LEFT_VIA_CARRY
    |-> O_RES.rd_we && O_RES.rd_val == {req_q.rd_val[6:0], pre_q[FLG_C]}
        && flags_q[FLG_C] == req_q.rd_val[7] && flags_q[FLG_H] == req_q.rd_val[3])
    else $error("rotate left result or flags wrong");
  rot_right_a: assert property (take_q && req_q.op == OP_ROTATE_RIGHT_VIA_CARRY
    |-> O_RES.rd_val == {pre_q[FLG_C], req_q.rd_val[7:1]}
        && flags_q[FLG_C] == req_q.rd_val[0] && flags_q[FLG_H] == pre_q[FLG_H])
    else $error("rotate right result or flags wrong");
  io_set_a: assert property (take_q && req_q.op == OP_IO_BIT_SET
    |-> O_RES.io_we && O_RES.io_val[req_q.bit_sel] && flags_q == pre_q)
    else $error("io bit set wrong");
  io_clear_a: assert property (take_q && req_q.op == OP_IO_BIT_CLEAR
    |-> O_RES.io_we && !O_RES.io_val[req_q.bit_sel] && flags_q == pre_q)
    else $error("io bit clear wrong");
  bit_to_t_a: assert property (take_q && req_q.op == OP_REG_BIT_TO_TRANSFER_FLAG
    |-> flags_q[FLG_T] == req_q.rd_val[req_q.bit_sel]
        && {flags_q[7], flags_q[5:0]} == {pre_q[7], pre_q[5:0]})
    else $error("bit to transfer flag wrong");
  t_to_bit_a: assert property (take_q && req_q.op == OP_TRANSFER_FLAG_TO_REG_BIT
    |-> O_RES.rd_we && O_RES.rd_val[req_q.bit_sel] == pre_q[FLG_T] && flags_q == pre_q)
    else $error("transfer flag to bit wrong");
  v_set_a: assert property (take_q && req_q.op == OP_STATUS_BIT_SET
    && req_q.bit_sel == FLG_V |-> flags_q == (pre_q | 8'h08))
    else $error("overflow set wrong");
  v_clear_a: assert property (take_q && req_q.op == OP_STATUS_BIT_CLEAR
    && req_q.bit_sel == FLG_V |-> flags_q == (pre_q & 8'hF7))
    else $error("overflow clear wrong");
  h_set_a: assert property (take_q && req_q.op == OP_STATUS_BIT_SET
    && req_q.bit_sel == FLG_H |-> flags_q == (pre_q | 8'h20))
    else $error("half carry set wrong");
  h_clear_a: assert property (take_q && req_q.op == OP_STATUS_BIT_CLEAR
    && req_q.bit_sel == FLG_H |-> flags_q == (pre_q & 8'hDF))
    else $error("half carry clear wrong");
  s_set_a: assert property (take_q && req_q.op == OP_STATUS_BIT_SET
    && req_q.bit_sel == FLG_S |-> flags_q == (pre_q | 8'h10))
    else $error("signed flag set wrong");
  s_clear_a: assert property (take_q && req_q.op == OP_STATUS_BIT_CLEAR
    && req_q.bit_sel == FLG_S |-> flags_q == (pre_q & 8'hEF))
    else $error("signed flag clear wrong");
  break_pulse_a: assert property (op_take && I_OP.op == OP_BREAK
    |=> O_BREAK && flags_q == $past(flags_q) ##1 !O_BREAK || op_take)
    else $error("break pulse wrong");
  slow_min_a: assert property ($rose(I_MEM_REQ && I_MEM_SLOW && !stall)
    |=> stall)
    else $error("slow access not stalled");
  slow_hold_a: assert property (stall && $past(stall) && (I_CTRL_BUSY || I_CTRL_CONTEND)
    |=> stall)
    else $error("stall ended while controller busy");
  stall_refuse_a: assert property (stall |-> !O_OP_READY && !op_take)
    else $error("operation taken during stall");
  left_fill_a: assert property (take_q && req_q.op == OP_LOGICAL_LEFT_SHIFT
    |-> O_RES.rd_val == {req_q.rd_val[6:0], 1'b0} && flags_q[FLG_C] == req_q.rd_val[7])
    else $error("logical left shift wrong");
  right_fill_a: assert property (take_q && req_q.op == OP_LOGICAL_RIGHT_SHIFT
    |-> O_RES.rd_val == {1'b0, req_q.rd_val[7:1]} && flags_q[FLG_C] == req_q.rd_val[0]
        && flags_q[FLG_H] == pre_q[FLG_H])
    else $error("logical right shift wrong");
  arith_keep_a: assert property (take_q && req_q.op == OP_ARITH_RIGHT_SHIFT
    |-> O_RES.rd_val == {req_q.rd_val[7], req_q.rd_val[7:1]})
    else $error("arithmetic right shift wrong");
  swap_flags_a: assert property (take_q && req_q.op == OP_NIBBLE_SWAP
    |-> O_RES.rd_val == {req_q.rd_val[3:0], req_q.rd_val[7:4]} && flags_q == pre_q)
    else $error("nibble swap wrong");
  set_only_a: assert property (take_q && req_q.op == OP_STATUS_BIT_SET
    |-> flags_q == (pre_q | (8'h01 << req_q.bit_sel)))
    else $error("status bit set touched other flags");
  clear_only_a: assert property (take_q && req_q.op == OP_STATUS_BIT_CLEAR
    |-> flags_q == (pre_q & ~(8'h01 << req_q.bit_sel)))
    else $error("status bit clear touched other flags");

  rotate_seen_c: cover property (take_q && req_q.op == OP_ROTATE_LEFT_VIA_CARRY);
  long_stall_c: cover property (stall [*3]);
  break_seen_c: cover property (O_BREAK);
  io_write_c: cover property (O_RES.io_we);

endmodule : bof_bit_ops_flag_unit
`default_nettype wire

// File: core/bof_nvm_stall.sv
`timescale 1ns/10ps
`default_nettype none
module bof_slow_stall
  import bof_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Access request
  input  wire logic       i_mem_req,
  input  wire logic       i_mem_slow,
  input  wire logic       i_ctrl_busy,
  input  wire logic       i_ctrl_contend,
  // Status
  output logic            o_stall,
  output logic [7:0]      o_last_stall
);

  typedef enum logic [1:0] {ST_IDLE, ST_MIN, ST_HOLD} bof_stall_st_t;

  bof_stall_st_t st_q;
  logic [7:0]    min_q;
  logic [7:0]    cnt_q;
  logic          hold_on;

  assign hold_on = i_ctrl_busy | i_ctrl_contend;
  assign o_stall = (st_q != ST_IDLE);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q  <= ST_IDLE;
      min_q <= STALL_CNT_RST;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (i_mem_req && i_mem_slow) begin
            st_q  <= ST_MIN;
            min_q <= SLOW_EXTRA_MIN - 8'h01;
          end
        end
        ST_MIN: begin
          if (min_q != 8'h00) begin
            min_q <= min_q - 8'h01;
          end else if (hold_on) begin
            st_q <= ST_HOLD;
          end else begin
            st_q <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (!hold_on) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Length of the current and last stall
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q        <= STALL_CNT_RST;
      o_last_stall <= STALL_CNT_RST;
    end else if (o_stall) begin
      cnt_q <= cnt_q + 8'h01;
    end else if (cnt_q != 8'h00) begin
      o_last_stall <= cnt_q;
      cnt_q        <= STALL_CNT_RST;
    end
  end

endmodule : bof_slow_stall
`default_nettype wire

// File: core/bof_shift_unit.sv
`timescale 1ns/10ps
`default_nettype none
module bof_shift_unit
  import bof_pkg::*;
(
  // Operand
  input  wire bof_op_t    i_op,
  input  wire logic [7:0] i_val,
  input  wire logic       i_carry,
  // Result
  output logic [7:0]      o_val,
  output logic            o_carry,
  output logic            o_half
);

  always_comb begin
    o_val   = i_val;
    o_carry = i_carry;
    o_half  = i_val[3];
    case (i_op)
      OP_LOGICAL_LEFT_SHIFT: begin
        o_val   = {i_val[6:0], 1'b0};
        o_carry = i_val[7];
      end
      OP_LOGICAL_RIGHT_SHIFT: begin
        o_val   = {1'b0, i_val[7:1]};
        o_carry = i_val[0];
      end
      OP_ROTATE_LEFT_VIA_CARRY: begin
        o_val   = {i_val[6:0], i_carry};
        o_carry = i_val[7];
      end
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        o_val   = {i_carry, i_val[7:1]};
        o_carry = i_val[0];
      end
      OP_ARITH_RIGHT_SHIFT: begin
        o_val   = {i_val[7], i_val[7:1]};
        o_carry = i_val[0];
      end
      OP_NIBBLE_SWAP: begin
        o_val = {i_val[3:0], i_val[7:4]};
      end
      default: begin
        o_val = i_val;
      end
    endcase
  end

endmodule : bof_shift_unit
`default_nettype wire

// File: inc/bof_pkg.sv
package bof_pkg;

  // Operation codes from the decoder
  typedef enum logic [3:0] {
    OP_NOP,
    OP_LOGICAL_LEFT_SHIFT,
    OP_LOGICAL_RIGHT_SHIFT,
    OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY,
    OP_ARITH_RIGHT_SHIFT,
    OP_NIBBLE_SWAP,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_REG_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_REG_BIT,
    OP_STATUS_BIT_SET,
    OP_STATUS_BIT_CLEAR,
    OP_BREAK,
    OP_SLEEP,
    OP_WATCHDOG_RESET
  } bof_op_t;

  // Status flag bit positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  localparam logic [7:0] FLAGS_RST = 8'h00;

  // Register port map
  localparam logic [3:0] REG_STATUS_FLAGS = 4'h0;
  localparam logic [3:0] REG_LAST_STALL   = 4'h1;
  localparam logic [3:0] REG_STALL_STATE  = 4'h2;

  // Least extra cycles for a nonvolatile-memory data access
  localparam logic [7:0] SLOW_EXTRA_MIN = 8'h01;
  localparam logic [7:0] STALL_CNT_RST = 8'h00;

  typedef struct packed {
    bof_op_t    op;
    logic [7:0] rd_val;
    logic [2:0] bit_sel;
    logic [4:0] io_addr;
    logic [7:0] io_val;
  } bof_req_t;

  typedef struct packed {
    logic       rd_we;
    logic [7:0] rd_val;
    logic       io_we;
    logic [4:0] io_addr;
    logic [7:0] io_val;
  } bof_res_t;

endpackage : bof_pkg

// File: sim/bof_dec_model.sv
`timescale 1ns/10ps
`default_nettype none
module bof_dec_model
  import bof_pkg::*;
(
  // Clock and reset
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  // Results from the unit
  input  wire bof_res_t i_res,
  // Register file contents
  output logic [7:0]    o_rd,
  output logic [7:0]    o_io
);
  logic [7:0] rd_q;
  logic [7:0] io_q;

  // Write back only on the one-cycle strobes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_q <= 8'h00;
    end else if (i_res.rd_we) begin
      rd_q <= i_res.rd_val;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      io_q <= 8'h00;
    end else if (i_res.io_we) begin
      io_q <= i_res.io_val;
    end
  end

  assign o_rd = rd_q;
  assign o_io = io_q;
endmodule : bof_dec_model
`default_nettype wire

// File: sim/test_bof_bit_ops_flag_unit.sv
`timescale 1ns/10ps
`default_nettype none
module test_bof_bit_ops_flag_unit
  import bof_pkg::*;
;
  typedef struct packed {
    bof_op_t    op;
    logic [7:0] sr;
    logic [7:0] rd;
    logic [2:0] b;
    logic [7:0] io;
    logic       rwe;
    logic       iwe;
    logic [7:0] val;
    logic [7:0] sx;
    logic [2:0] pul;
  } bof_row_t;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       op_valid = 1'b0;
  bof_req_t   req = '0;
  logic       mem_req = 1'b0;
  logic       mem_slow = 1'b0;
  logic       busy = 1'b0;
  logic       cont = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       op_ready, brk, slp, wdr, stall;
  bof_res_t   res;
  logic [7:0] flags, reg_rdata, part_rd;
  int         fail_count = 0;
  int         comparisons = 0;
  int         n;
  bof_row_t   r;

  bof_row_t rows [14] = '{
    '{OP_LOGICAL_LEFT_SHIFT, 8'h10, 8'h81, 3'h0, 8'h00, 1'b1, 1'b0, 8'h02, 8'h19, 3'h0},
    '{OP_LOGICAL_RIGHT_SHIFT, 8'h00, 8'h01, 3'h0, 8'h00, 1'b1, 1'b0, 8'h00, 8'h0B, 3'h0},
    '{OP_ROTATE_LEFT_VIA_CARRY, 8'h01, 8'h40, 3'h0, 8'h00, 1'b1, 1'b0, 8'h81, 8'h0C, 3'h0},
    '{OP_ROTATE_RIGHT_VIA_CARRY, 8'h21, 8'h01, 3'h0, 8'h00, 1'b1, 1'b0, 8'h80, 8'h25, 3'h0},
    '{OP_ARITH_RIGHT_SHIFT, 8'h00, 8'h82, 3'h0, 8'h00, 1'b1, 1'b0, 8'hC1, 8'h0C, 3'h0},
    '{OP_NIBBLE_SWAP, 8'hFF, 8'hA5, 3'h0, 8'h00, 1'b1, 1'b0, 8'h5A, 8'hFF, 3'h0},
    '{OP_IO_BIT_SET, 8'h55, 8'h00, 3'h7, 8'h00, 1'b0, 1'b1, 8'h80, 8'h55, 3'h0},
    '{OP_IO_BIT_CLEAR, 8'hAA, 8'h00, 3'h0, 8'hFF, 1'b0, 1'b1, 8'hFE, 8'hAA, 3'h0},
    '{OP_REG_BIT_TO_TRANSFER_FLAG, 8'h00, 8'h08, 3'h3, 8'h00, 1'b0, 1'b0, 8'h00, 8'h40, 3'h0},
    '{OP_TRANSFER_FLAG_TO_REG_BIT, 8'h40, 8'h00, 3'h5, 8'h00, 1'b1, 1'b0, 8'h20, 8'h40, 3'h0},
    '{OP_BREAK, 8'h3C, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00, 8'h3C, 3'h4},
    '{OP_SLEEP, 8'h3C, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00, 8'h3C, 3'h2},
    '{OP_WATCHDOG_RESET, 8'h3C, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00, 8'h3C, 3'h1},
    '{OP_NOP, 8'h3C, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0, 8'h00, 8'h3C, 3'h0}
  };

  always #2.5 clk = ~clk;

  bof_bit_ops_flag_unit uut (
    .I_CLK(clk), .I_RST(rst), .I_OP_VALID(op_valid), .I_OP(req), .O_OP_READY(op_ready),
    .O_RES(res), .O_FLAGS(flags), .O_BREAK(brk), .O_SLEEP(slp), .O_WDR(wdr),
    .I_MEM_REQ(mem_req), .I_MEM_SLOW(mem_slow), .I_CTRL_BUSY(busy), .I_CTRL_CONTEND(cont),
    .O_STALL(stall), .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr),
    .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata)
  );

  bof_dec_model dec (
    .i_clk(clk), .i_rst(rst), .i_res(res), .o_rd(part_rd), .o_io()
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge clk);
  endtask : rd_reg

  task automatic run_row(input bof_row_t x);
    wr_reg(REG_STATUS_FLAGS, x.sr);
    op_valid <= 1'b1;
    req      <= '{op: x.op, rd_val: x.rd, bit_sel: x.b, io_addr: 5'h0B, io_val: x.io};
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    chk(res.rd_we, x.rwe);
    chk(res.io_we, x.iwe);
    if (x.rwe) chk(res.rd_val, x.val);
    if (x.iwe) chk({res.io_addr, 3'h0}, 8'h58);
    if (x.iwe) chk(res.io_val, x.val);
    chk(flags, x.sx);
    chk({brk, slp, wdr}, x.pul);
    @(posedge clk);
  endtask : run_row

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    #(5 * 3000);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk(flags, FLAGS_RST);
    chk({op_ready, stall, res.rd_we, res.io_we}, 8'h08);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) run_row(rows[i]);
    // Every status flag set from clear, then cleared from set
    for (int f = 0; f < 8; f++) begin
      r = '{OP_STATUS_BIT_SET, 8'h00, 8'h00, f[2:0], 8'h00, 1'b0, 1'b0, 8'h00, 8'h01 << f, 3'h0};
      run_row(r);
      r.op = OP_STATUS_BIT_CLEAR;
      r.sr = 8'hFF;
      r.sx = ~(8'h01 << f);
      run_row(r);
    end
    rd_reg(REG_STATUS_FLAGS, 8'h7F);
    wr_reg(4'hF, 8'h00);
    rd_reg(4'hF, 8'h00);
    rd_reg(REG_STATUS_FLAGS, 8'h7F);
    // Mid-run reset clears the flags
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(flags, FLAGS_RST);
    @(posedge clk);
    // Back to back: set carry then rotate it in
    op_valid <= 1'b1;
    req      <= '{op: OP_STATUS_BIT_SET, rd_val: 8'h00, bit_sel: FLG_C, io_addr: 5'h00, io_val: 8'h00};
    @(posedge clk);
    req.op <= OP_ROTATE_LEFT_VIA_CARRY;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    chk(res.rd_val, 8'h01);
    chk(flags, 8'h00);
    @(posedge clk);
    #1;
    chk(part_rd, 8'h01);
    @(posedge clk);
    // Stalls: internal RAM, plain nonvolatile, busy, contention
    for (int j = 0; j < 4; j++) begin
      n = (j == 0) ? 0 : (j == 1) ? 1 : 3;
      mem_req <= 1'b1;
      mem_slow <= (j != 0);
      @(posedge clk);
      mem_req  <= 1'b0;
      busy     <= (j == 2);
      cont     <= (j == 3);
      op_valid <= 1'b1;
      req      <= '{op: OP_LOGICAL_LEFT_SHIFT, rd_val: 8'h01, bit_sel: 3'h0,
                    io_addr: 5'h00, io_val: 8'h00};
      for (int c = 1; c <= 4; c++) begin
        #1;
        chk(stall, (c <= n));
        chk(op_ready, (c > n));
        if (c <= n) chk(res.rd_we, (c > 1) && (c - 1 > n));
        @(posedge clk);
        if (c == 1) op_valid <= 1'b0;
        if (c == 2) begin
          busy <= 1'b0;
          cont <= 1'b0;
        end
      end
      if (j != 0) rd_reg(REG_LAST_STALL, n[7:0]);
    end
    rd_reg(REG_STALL_STATE, 8'h00);
    complete_run();
  end
endmodule : test_bof_bit_ops_flag_unit
`default_nettype wire
